// ===== fsc_cfg.svh
`ifndef FSC_CFG_SVH
`define FSC_CFG_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define FSC_CLK_PERIOD_NS        4
`define FSC_SUSPEND_LATENCY_NS   20000
// Longest time, so the cycle count rounds down
`define FSC_SUSPEND_LATENCY_CYC  (`FSC_SUSPEND_LATENCY_NS / `FSC_CLK_PERIOD_NS)

// ****************************************************************
// Frame layout
// ****************************************************************
`define FSC_BYTE_LAST_BIT        3'h7
`define FSC_BYTES_SAT            3'h4
`define FSC_BYTE_OPCODE          3'h0
`define FSC_BYTE_BLOCK           3'h1

// ****************************************************************
// Opcodes
// ****************************************************************
`define FSC_OP_SUSPEND_A         8'h75
`define FSC_OP_SUSPEND_B         8'hB0
`define FSC_OP_RESUME_A          8'h7A
`define FSC_OP_RESUME_B          8'hD0
`define FSC_OP_WREN              8'h06
`define FSC_OP_WRDI              8'h04
`define FSC_OP_VWREN             8'h50
`define FSC_OP_RD_03             8'h03
`define FSC_OP_RD_0B             8'h0B
`define FSC_OP_RD_3B             8'h3B
`define FSC_OP_RD_6B             8'h6B
`define FSC_OP_RD_EB             8'hEB
`define FSC_OP_RD_E7             8'hE7
`define FSC_OP_LOCKSTAT_A        8'h3C
`define FSC_OP_LOCKSTAT_B        8'h3D
`define FSC_OP_RD_SECREG         8'h4B
`define FSC_OP_RD_PARAM          8'h5A
`define FSC_OP_WRAP              8'h77
`define FSC_OP_PROG_02           8'h02
`define FSC_OP_PROG_A2           8'hA2
`define FSC_OP_PROG_32           8'h32
`define FSC_OP_SEQ_AD            8'hAD
`define FSC_OP_SEQ_AF            8'hAF
`define FSC_OP_RDSR_1            8'h05
`define FSC_OP_RDSR_2            8'h35
`define FSC_OP_RDSR_3            8'h15
`define FSC_OP_RDSR_IND          8'h65
`define FSC_OP_TERMINATE         8'hF0
`define FSC_OP_RST_EN            8'h66
`define FSC_OP_RST               8'h99
`define FSC_OP_ID_9F             8'h9F
`define FSC_OP_ID_90             8'h90
`define FSC_OP_ID_94             8'h94
`define FSC_OP_WAKE              8'hAB
`define FSC_OP_BE_20             8'h20
`define FSC_OP_BE_52             8'h52
`define FSC_OP_BE_D8             8'hD8
`define FSC_OP_CE_60             8'h60
`define FSC_OP_CE_C7             8'hC7
`define FSC_OP_LOCK_BLK          8'h36
`define FSC_OP_UNLOCK_BLK        8'h39
`define FSC_OP_LOCK_ALL          8'h7E
`define FSC_OP_UNLOCK_ALL        8'h98
`define FSC_OP_PROG_SECREG       8'h9B
`define FSC_OP_WRSR_1            8'h01
`define FSC_OP_WRSR_2            8'h31
`define FSC_OP_WRSR_3            8'h11
`define FSC_OP_WRSR_IND          8'h71
`define FSC_OP_SR_LOCK           8'h6F
`define FSC_OP_DPD               8'hB9
`define FSC_OP_UDPD              8'h79

`endif

// ===== fsc_gate.sv
// Summary of operation
// - Opcodes 75h and B0h both request suspend, identically.
// - Suspend is opcode only on the serial input; no address or data.
// - Opcode shifts in over eight clocks, MSB first, chip select held low.
// - After chip select rises on a valid suspend, halt the operation within latency.
// - On suspend set suspended flag and program or erase suspended flag.
// - On suspend clear the busy flag.
// - Disallowed commands do nothing and leave the write enable latch alone.
// - Suspend accepted only while active, a program under an erase suspend included; rejected when suspended and not busy.
// - Status register reads accepted in every state.
// - ID reads, terminate, reset enable, reset, wake accepted in every state.
// - Reads, wrap, write enables/disable, resume: rejected busy, accepted suspended.
// - Program rejected busy or program-suspended; erase-suspended only in other 64 kB block.
// - Erase, lock, unlock, secure program, status writes, power-downs rejected busy or suspended; accepted only idle.
// - Suspend ignored during status writes, lock, secure program, chip erase, sequential program.
// - Suspend needs whole opcode and chip select rise on a byte boundary.
// - Suspend honoured whatever the write enable latch holds.
`timescale 1ns/10ps
`include "fsc_cfg.svh"

module fsc_gate
    import fsc_pkg::*;
#(
    parameter int SUSPEND_LATENCY_CYCLES = `FSC_SUSPEND_LATENCY_CYC
)
(
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // Serial host pins
    input  wire logic       sclk_in,
    input  wire logic       cs_n_in,
    input  wire logic       si_in,
    // Program and erase engine
    input  wire logic       op_start_in,
    input  wire logic       op_erase_in,
    input  wire logic       op_suspendable_in,
    input  wire logic [7:0] op_block_in,
    input  wire logic       op_done_in,
    output logic            suspend_req_out,
    output logic            resume_req_out,
    // Command results
    output logic            cmd_done_out,
    output logic            cmd_accepted_out,
    output logic [7:0]      cmd_opcode_out,
    output logic [7:0]      cmd_block_out,
    // Status flags
    output logic            busy_flag_out,
    output logic            suspended_flag_out,
    output logic            program_suspended_flag_out,
    output logic            erase_suspended_flag_out,
    output logic            write_enable_latch_out
);

    // ****************************************************************
    // Serial capture
    // ****************************************************************
    logic       sclk_prev_reg;
    logic       sclk_prev_next;
    logic       cs_prev_reg;
    logic       cs_prev_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [2:0] phase_reg;
    logic [2:0] phase_next;
    logic [2:0] bytes_reg;
    logic [2:0] bytes_next;
    logic [7:0] opcode_reg;
    logic [7:0] opcode_next;
    logic [7:0] blk_reg;
    logic [7:0] blk_next;
    logic [7:0] byte_in;

    assign byte_in = {shift_reg[6:0], si_in};

    always_comb
    begin
        sclk_prev_next = sclk_in;
        cs_prev_next   = cs_n_in;
        shift_next     = shift_reg;
        phase_next     = phase_reg;
        bytes_next     = bytes_reg;
        opcode_next    = opcode_reg;
        blk_next       = blk_reg;
        if (cs_n_in)
        begin
            phase_next = 3'h0;
            bytes_next = 3'h0;
        end
        else if (sclk_in && !sclk_prev_reg)
        begin
            // Rising edge of the serial clock, MSB first
            shift_next = byte_in;
            phase_next = phase_reg + 3'h1;
            if (phase_reg == `FSC_BYTE_LAST_BIT)
            begin
                if (bytes_reg == `FSC_BYTE_OPCODE)
                begin
                    opcode_next = byte_in;
                end
                else if (bytes_reg == `FSC_BYTE_BLOCK)
                begin
                    blk_next = byte_in;
                end
                if (bytes_reg != `FSC_BYTES_SAT)
                begin
                    bytes_next = bytes_reg + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sclk_prev_reg <= 1'b0;
            cs_prev_reg   <= 1'b1;
            shift_reg     <= 8'h00;
            phase_reg     <= 3'h0;
            bytes_reg     <= 3'h0;
            opcode_reg    <= 8'h00;
            blk_reg       <= 8'h00;
        end
        else
        begin
            sclk_prev_reg <= sclk_prev_next;
            cs_prev_reg   <= cs_prev_next;
            shift_reg     <= shift_next;
            phase_reg     <= phase_next;
            bytes_reg     <= bytes_next;
            opcode_reg    <= opcode_next;
            blk_reg       <= blk_next;
        end
    end

    // ****************************************************************
    // Command gating
    // ****************************************************************
    logic       busy_reg;
    logic       psusp_reg;
    logic       esusp_reg;
    logic       halting_reg;
    logic       op_suspended_flag_ok_reg;
    logic [7:0] erase_blk_reg;
    fsc_class_t op_class;
    fsc_state_t state;
    logic       frame_end;
    logic       frame_ok;
    logic       accept;

    fsc_opcode_class u_class
    (
        .opcode_in (opcode_reg),
        .class_out (op_class)
    );

    always_comb
    begin
        if (busy_reg)
        begin
            state = ST_ACTIVE;
        end
        else if (psusp_reg)
        begin
            state = ST_PROG_SUSPENDED_FLAG;
        end
        else if (esusp_reg)
        begin
            state = ST_ERASE_SUSPENDED_FLAG;
        end
        else
        begin
            state = ST_IDLE;
        end
    end

    assign frame_end = cs_n_in && !cs_prev_reg;
    // A torn byte voids the whole frame
    assign frame_ok  = (bytes_reg != 3'h0) && (phase_reg == 3'h0);

    always_comb
    begin
        case (op_class)
            CL_ANY:
                accept = 1'b1;
            CL_SUSPENDED_FLAG_OK:
                accept = (state != ST_ACTIVE);
            CL_RESUME:
                accept = (state == ST_PROG_SUSPENDED_FLAG) || (state == ST_ERASE_SUSPENDED_FLAG);
            CL_PROGRAM:
                accept = (state == ST_IDLE) ||
                         ((state == ST_ERASE_SUSPENDED_FLAG) && (bytes_reg > `FSC_BYTE_BLOCK) &&
                          (blk_reg != erase_blk_reg));
            // Write enable latch plays no part here
            CL_SUSPEND:
                accept = (state == ST_ACTIVE) && op_suspended_flag_ok_reg && !halting_reg &&
                         (bytes_reg == `FSC_BYTE_BLOCK);
            CL_NEVER:
                accept = (state == ST_IDLE);
            default:
                accept = (state == ST_IDLE);
        endcase
    end

    // ****************************************************************
    // Status flags and engine control
    // ****************************************************************
    logic        busy_next;
    logic        psusp_next;
    logic        esusp_next;
    logic        suspended_flag_reg;
    logic        suspended_flag_next;
    logic        wel_reg;
    logic        wel_next;
    logic        halting_next;
    logic [15:0] halt_cnt_reg;
    logic [15:0] halt_cnt_next;
    logic        op_erase_reg;
    logic        op_erase_next;
    logic        op_suspended_flag_ok_next;
    logic [7:0]  op_blk_reg;
    logic [7:0]  op_blk_next;
    logic [7:0]  erase_blk_next;
    logic        resume_req_reg;
    logic        resume_req_next;
    logic        done_reg;
    logic        done_next;
    logic        acc_reg;
    logic        acc_next;
    logic [7:0]  cmd_op_reg;
    logic [7:0]  cmd_op_next;
    logic [7:0]  cmd_blk_reg;
    logic [7:0]  cmd_blk_next;

    always_comb
    begin
        busy_next       = busy_reg;
        psusp_next      = psusp_reg;
        esusp_next      = esusp_reg;
        suspended_flag_next       = suspended_flag_reg;
        wel_next        = wel_reg;
        halting_next    = halting_reg;
        halt_cnt_next   = halt_cnt_reg;
        op_erase_next   = op_erase_reg;
        op_suspended_flag_ok_next = op_suspended_flag_ok_reg;
        op_blk_next     = op_blk_reg;
        erase_blk_next  = erase_blk_reg;
        resume_req_next = 1'b0;
        done_next       = 1'b0;
        acc_next        = acc_reg;
        cmd_op_next     = cmd_op_reg;
        cmd_blk_next    = cmd_blk_reg;

        // Rejected frames still report, but touch no state
        if (frame_end && frame_ok)
        begin
            done_next    = 1'b1;
            acc_next     = accept;
            cmd_op_next  = opcode_reg;
            cmd_blk_next = blk_reg;
            if (accept)
            begin
                if (opcode_reg == `FSC_OP_WREN)
                begin
                    wel_next = 1'b1;
                end
                else if (opcode_reg == `FSC_OP_WRDI)
                begin
                    wel_next = 1'b0;
                end
                else if (op_class == CL_SUSPEND)
                begin
                    halting_next  = 1'b1;
                    halt_cnt_next = 16'h0000;
                end
                else if (op_class == CL_RESUME)
                begin
                    // A nested program resumes before the erase under it
                    resume_req_next = 1'b1;
                    busy_next       = 1'b1;
                    op_suspended_flag_ok_next = 1'b1;
                    if (psusp_reg)
                    begin
                        psusp_next    = 1'b0;
                        suspended_flag_next     = esusp_reg;
                        op_erase_next = 1'b0;
                    end
                    else
                    begin
                        esusp_next    = 1'b0;
                        suspended_flag_next     = 1'b0;
                        op_erase_next = 1'b1;
                        op_blk_next   = erase_blk_reg;
                    end
                end
            end
        end

        if (halting_reg)
        begin
            if (op_done_in)
            begin
                // Engine finished before it could be halted
                halting_next = 1'b0;
            end
            else if (halt_cnt_reg == 16'(SUSPEND_LATENCY_CYCLES - 1))
            begin
                halting_next = 1'b0;
                busy_next    = 1'b0;
                suspended_flag_next    = 1'b1;
                if (op_erase_reg)
                begin
                    esusp_next     = 1'b1;
                    erase_blk_next = op_blk_reg;
                end
                else
                begin
                    psusp_next = 1'b1;
                end
            end
            else
            begin
                halt_cnt_next = halt_cnt_reg + 16'h0001;
            end
        end

        if (op_done_in)
        begin
            busy_next = 1'b0;
        end

        // A new operation wins over any clear in the same cycle
        if (op_start_in)
        begin
            busy_next       = 1'b1;
            op_erase_next   = op_erase_in;
            op_suspended_flag_ok_next = op_suspendable_in;
            op_blk_next     = op_block_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            busy_reg       <= 1'b0;
            psusp_reg      <= 1'b0;
            esusp_reg      <= 1'b0;
            suspended_flag_reg       <= 1'b0;
            wel_reg        <= 1'b0;
            halting_reg    <= 1'b0;
            halt_cnt_reg   <= 16'h0000;
            op_erase_reg   <= 1'b0;
            op_suspended_flag_ok_reg <= 1'b0;
            op_blk_reg     <= 8'h00;
            erase_blk_reg  <= 8'h00;
            resume_req_reg <= 1'b0;
            done_reg       <= 1'b0;
            acc_reg        <= 1'b0;
            cmd_op_reg     <= 8'h00;
            cmd_blk_reg    <= 8'h00;
        end
        else
        begin
            busy_reg       <= busy_next;
            psusp_reg      <= psusp_next;
            esusp_reg      <= esusp_next;
            suspended_flag_reg       <= suspended_flag_next;
            wel_reg        <= wel_next;
            halting_reg    <= halting_next;
            halt_cnt_reg   <= halt_cnt_next;
            op_erase_reg   <= op_erase_next;
            op_suspended_flag_ok_reg <= op_suspended_flag_ok_next;
            op_blk_reg     <= op_blk_next;
            erase_blk_reg  <= erase_blk_next;
            resume_req_reg <= resume_req_next;
            done_reg       <= done_next;
            acc_reg        <= acc_next;
            cmd_op_reg     <= cmd_op_next;
            cmd_blk_reg    <= cmd_blk_next;
        end
    end

    assign suspend_req_out            = halting_reg;
    assign resume_req_out             = resume_req_reg;
    assign cmd_done_out               = done_reg;
    assign cmd_accepted_out           = acc_reg;
    assign cmd_opcode_out             = cmd_op_reg;
    assign cmd_block_out              = cmd_blk_reg;
    assign busy_flag_out              = busy_reg;
    assign suspended_flag_out         = suspended_flag_reg;
    assign program_suspended_flag_out = psusp_reg;
    assign erase_suspended_flag_out   = esusp_reg;
    assign write_enable_latch_out     = wel_reg;

endmodule

// ===== fsc_gate_sva.sv
`timescale 1ns/10ps
`include "fsc_cfg.svh"

module fsc_gate_sva
    import fsc_pkg::*;
#(
    parameter int SUSPEND_LATENCY_CYCLES = `FSC_SUSPEND_LATENCY_CYC
)
(
    // Clock and reset
    input wire logic       clk_in,
    input wire logic       rst_in,
    // Engine
    input wire logic       suspend_req_out,
    input wire logic       resume_req_out,
    // Command results
    input wire logic       cmd_done_out,
    input wire logic       cmd_accepted_out,
    input wire logic [7:0] cmd_opcode_out,
    // Status flags
    input wire logic       busy_flag_out,
    input wire logic       suspended_flag_out,
    input wire logic       program_suspended_flag_out,
    input wire logic       erase_suspended_flag_out,
    input wire logic       write_enable_latch_out
);
    // Cycles the halt request has stood
    logic [16:0] high_reg;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            high_reg <= 17'h0_0000;
        else
            high_reg <= suspend_req_out ? high_reg + 17'h0_0001 : 17'h0_0000;
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_halt_start;
        $rose(suspend_req_out);
    endsequence

    sequence s_halt_done;
        $rose(program_suspended_flag_out) || $rose(erase_suspended_flag_out);
    endsequence

    chk_halt_cause: assert property (
        s_halt_start |-> cmd_done_out && cmd_accepted_out && $past(busy_flag_out)
        && cmd_opcode_out inside {8'h75, 8'hB0}) else $error("stray halt");
    chk_halt_bound: assert property (
        high_reg <= 17'(SUSPEND_LATENCY_CYCLES)) else $error("halt too long");
    chk_halt_exact: assert property (
        s_halt_done |-> !suspend_req_out && high_reg == 17'(SUSPEND_LATENCY_CYCLES))
        else $error("halt end early");
    chk_flags_set: assert property (
        $rose(suspended_flag_out) |-> !busy_flag_out
        && (program_suspended_flag_out || erase_suspended_flag_out)) else $error("bad suspend flags");
    chk_reads_ok: assert property (
        cmd_done_out && cmd_opcode_out inside {8'h05, 8'h35, 8'h15, 8'h65, 8'h9F, 8'h90, 8'h94,
        8'hF0, 8'h66, 8'h99, 8'hAB} |-> cmd_accepted_out) else $error("status read refused");
    chk_busy_reject: assert property (
        cmd_done_out && $past(busy_flag_out) && cmd_opcode_out inside {8'h03, 8'hEB, 8'h5A, 8'h3C,
        8'h4B, 8'h77, 8'h06, 8'h04, 8'h50, 8'h7A, 8'hD0} |-> !cmd_accepted_out)
        else $error("accepted while busy");
    chk_resume_cause: assert property (
        resume_req_out |-> cmd_done_out && cmd_accepted_out && cmd_opcode_out inside {8'h7A, 8'hD0})
        else $error("stray resume");
    chk_prog_reject: assert property (
        cmd_done_out && $past(busy_flag_out || program_suspended_flag_out)
        && cmd_opcode_out inside {8'h02, 8'hA2, 8'h32, 8'hAD, 8'hAF} |-> !cmd_accepted_out)
        else $error("bad program accept");
    chk_never_ok: assert property (
        cmd_done_out && $past(busy_flag_out || program_suspended_flag_out || erase_suspended_flag_out)
        && cmd_opcode_out inside {8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h36, 8'h39, 8'h7E, 8'h98,
        8'h9B, 8'h01, 8'h31, 8'h11, 8'h71, 8'h6F, 8'hB9, 8'h79} |-> !cmd_accepted_out)
        else $error("forbidden accepted");
    chk_wel_hold: assert property (
        cmd_done_out && !cmd_accepted_out |-> $stable(write_enable_latch_out)
        ##1 $stable(write_enable_latch_out)) else $error("write latch moved");
endmodule

bind fsc_gate fsc_gate_sva #(.SUSPEND_LATENCY_CYCLES(SUSPEND_LATENCY_CYCLES)) chk_i (.*);

// ===== fsc_host_model.sv
`timescale 1ns/10ps

module fsc_host_model
(
    // Clock
    input  wire logic clk_in,
    // Serial pins
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      si_out
);
    initial {sclk_out, cs_n_out, si_out} = 3'b010;

    // Clock idles low; a released data line shows the inverse
    task automatic send(input logic [15:0] frame, input int nbits, input int half);
        @(posedge clk_in);
        #1 cs_n_out = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            si_out = frame[15 - i];
            repeat (half) @(posedge clk_in);
            #1 sclk_out = 1'b1;
            repeat (half) @(posedge clk_in);
            #1 sclk_out = 1'b0;
        end
        repeat (half) @(posedge clk_in);
        #1 cs_n_out = 1'b1;
        si_out = ~si_out;
        repeat (4) @(posedge clk_in);
    endtask
endmodule

// ===== fsc_opcode_class.sv
`timescale 1ns/10ps
`include "fsc_cfg.svh"

module fsc_opcode_class
    import fsc_pkg::*;
(
    // Opcode to sort
    input  wire logic [7:0] opcode_in,
    // Gating class
    output fsc_class_t      class_out
);

    always_comb
    begin
        case (opcode_in)
            `FSC_OP_SUSPEND_A, `FSC_OP_SUSPEND_B:
                class_out = CL_SUSPEND;
            `FSC_OP_RDSR_1, `FSC_OP_RDSR_2, `FSC_OP_RDSR_3, `FSC_OP_RDSR_IND:
                class_out = CL_ANY;
            `FSC_OP_ID_9F, `FSC_OP_ID_90, `FSC_OP_ID_94, `FSC_OP_TERMINATE,
            `FSC_OP_RST_EN, `FSC_OP_RST, `FSC_OP_WAKE:
                class_out = CL_ANY;
            `FSC_OP_RESUME_A, `FSC_OP_RESUME_B:
                class_out = CL_RESUME;
            `FSC_OP_RD_03, `FSC_OP_RD_0B, `FSC_OP_RD_3B, `FSC_OP_RD_6B,
            `FSC_OP_RD_EB, `FSC_OP_RD_E7, `FSC_OP_LOCKSTAT_A, `FSC_OP_LOCKSTAT_B,
            `FSC_OP_RD_SECREG, `FSC_OP_RD_PARAM, `FSC_OP_WRAP, `FSC_OP_WREN,
            `FSC_OP_WRDI, `FSC_OP_VWREN:
                class_out = CL_SUSPENDED_FLAG_OK;
            `FSC_OP_PROG_02, `FSC_OP_PROG_A2, `FSC_OP_PROG_32,
            `FSC_OP_SEQ_AD, `FSC_OP_SEQ_AF:
                class_out = CL_PROGRAM;
            `FSC_OP_BE_20, `FSC_OP_BE_52, `FSC_OP_BE_D8, `FSC_OP_CE_60,
            `FSC_OP_CE_C7, `FSC_OP_LOCK_BLK, `FSC_OP_UNLOCK_BLK, `FSC_OP_LOCK_ALL,
            `FSC_OP_UNLOCK_ALL, `FSC_OP_PROG_SECREG, `FSC_OP_WRSR_1, `FSC_OP_WRSR_2,
            `FSC_OP_WRSR_3, `FSC_OP_WRSR_IND, `FSC_OP_SR_LOCK, `FSC_OP_DPD,
            `FSC_OP_UDPD:
                class_out = CL_NEVER;
            default:
                class_out = CL_OTHER;
        endcase
    end

endmodule

// ===== fsc_pkg.sv
package fsc_pkg;

    // Acceptance state, derived from the status flags
    typedef enum logic [1:0]
    {
        ST_IDLE,
        ST_ACTIVE,
        ST_PROG_SUSPENDED_FLAG,
        ST_ERASE_SUSPENDED_FLAG
    } fsc_state_t;

    // How an opcode is gated
    typedef enum logic [2:0]
    {
        CL_ANY,
        CL_SUSPENDED_FLAG_OK,
        CL_RESUME,
        CL_PROGRAM,
        CL_SUSPEND,
        CL_NEVER,
        CL_OTHER
    } fsc_class_t;

endpackage

// ===== tb_top.sv
`timescale 1ns/10ps

module tb_top;
    localparam int LAT = 8;
    logic       clk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic       op_start = 1'b0;
    logic       op_erase = 1'b0;
    logic       op_suspended_flag = 1'b0;
    logic       op_done = 1'b0;
    logic [7:0] op_blk = 8'h00;
    wire logic  sclk, cs_n, si;
    logic       sreq, rreq, done, acc, busy, suspended_flag, ps, es, write_enable_latch;
    logic [7:0] cop, cblk;
    logic [17:0] seen;
    logic       wel_exp = 1'b0;
    logic [7:0] rnd = 8'h0B;
    logic [7:0] eblk = 8'h00;
    int         bad_count = 0;
    int         comparisons = 0;
    int         st = 0;
    logic [7:0] ops [30] = '{8'h03, 8'hEB, 8'h5A, 8'h3C, 8'h4B, 8'h77, 8'h06, 8'h04, 8'h50, 8'h05,
        8'h65, 8'h35, 8'h9F, 8'hF0, 8'h66, 8'h99, 8'hAB, 8'h20, 8'h60, 8'hC7, 8'h36, 8'h7E, 8'h9B,
        8'h01, 8'h71, 8'h6F, 8'hB9, 8'h79, 8'h02, 8'hAD};

    always #2 clk_in = ~clk_in;

    // Clear of the register updates
    always @(negedge clk_in)
    begin
        if (done === 1'b1)
            seen = {done, acc, cop, cblk};
    end

    fsc_gate #(.SUSPEND_LATENCY_CYCLES(LAT)) uut
    (
        .clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk), .cs_n_in(cs_n), .si_in(si),
        .op_start_in(op_start), .op_erase_in(op_erase), .op_suspendable_in(op_suspended_flag),
        .op_block_in(op_blk), .op_done_in(op_done), .suspend_req_out(sreq), .resume_req_out(rreq),
        .cmd_done_out(done), .cmd_accepted_out(acc), .cmd_opcode_out(cop), .cmd_block_out(cblk),
        .busy_flag_out(busy), .suspended_flag_out(suspended_flag), .program_suspended_flag_out(ps),
        .erase_suspended_flag_out(es), .write_enable_latch_out(write_enable_latch)
    );
    fsc_host_model host (.clk_in(clk_in), .sclk_out(sclk), .cs_n_out(cs_n), .si_out(si));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic logic [7:0] step(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    // st: 0 idle, 1 busy, 2 program, 3 erase suspended
    function automatic logic expect_acc(input logic [7:0] op, input logic [7:0] b);
        if (op inside {8'h05, 8'h35, 8'h15, 8'h65, 8'h9F, 8'h90, 8'h94, 8'hF0, 8'h66, 8'h99, 8'hAB})
            return 1'b1;
        if (op inside {8'h20, 8'h60, 8'hC7, 8'h36, 8'h7E, 8'h9B, 8'h01, 8'h71, 8'h6F, 8'hB9, 8'h79})
            return st == 0;
        if (op inside {8'h02, 8'hAD})
            return st == 0 || (st == 3 && b != eblk);
        return st != 1;
    endfunction

    task automatic flags(input logic [3:0] f);
        check({3'h0, busy, suspended_flag, ps, es, write_enable_latch}, {3'h0, f, wel_exp});
    endtask

    task automatic frame(input logic [7:0] op, input int nbits, input logic [7:0] b, input logic exp);
        seen = 18'h0_0000;
        rnd = step(rnd);
        host.send({op, b}, nbits, rnd[0] ? 1 : 3);
        if (exp && op inside {8'h06, 8'h04})
            wel_exp = (op == 8'h06);
        check({6'h00, seen[17:16]}, {6'h00, nbits % 8 == 0, exp && nbits % 8 == 0});
        check(seen[15:8], nbits % 8 ? 8'h00 : op);
        if (nbits == 16)
            check(seen[7:0], b);
    endtask

    task automatic engine(input logic start, input logic erase, input logic sus, input logic [7:0] blk);
        @(posedge clk_in);
        #1 {op_start, op_done, op_erase, op_suspended_flag, op_blk} = {start, ~start, erase, sus, blk};
        @(posedge clk_in);
        #1 {op_start, op_done} = 2'b00;
        repeat (2) @(posedge clk_in);
    endtask

    task automatic rand_ops(input int n);
        logic [7:0] op, b;
        repeat (n)
        begin
            rnd = step(rnd);
            op = ops[rnd % 30];
            rnd = step(rnd);
            b = rnd[0] ? eblk : rnd;
            frame(op, 16, b, expect_acc(op, b));
            check({7'h00, write_enable_latch}, {7'h00, wel_exp});
        end
    endtask

    initial
    begin
        repeat (10) @(posedge clk_in);
        #1 rst_in = 1'b0;
        flags(4'h0);
        frame(8'h75, 8, 8'h00, 1'b0);
        frame(8'h06, 8, 8'h00, 1'b1);
        engine(1'b1, 1'b1, 1'b1, 8'h05);
        eblk = 8'h05;
        st = 1;
        flags(4'h8);
        rand_ops(10);
        frame(8'h75, 5, 8'h00, 1'b0);
        frame(8'h75, 16, 8'h00, 1'b0);
        frame(8'hB0, 8, 8'h00, 1'b1);
        repeat (LAT + 4) @(posedge clk_in);
        st = 3;
        flags(4'h5);
        frame(8'h75, 8, 8'h00, 1'b0);
        frame(8'h02, 16, 8'h05, 1'b0);
        frame(8'h02, 16, 8'h06, 1'b1);
        rand_ops(12);
        frame(8'h04, 8, 8'h00, 1'b1);
        engine(1'b1, 1'b0, 1'b1, 8'h09);
        st = 1;
        flags(4'hD);
        frame(8'h75, 8, 8'h00, 1'b1);
        repeat (LAT + 4) @(posedge clk_in);
        st = 2;
        flags(4'h7);
        rand_ops(8);
        frame(8'h7A, 8, 8'h00, 1'b1);
        flags(4'hD);
        engine(1'b0, 1'b0, 1'b0, 8'h00);
        st = 3;
        flags(4'h5);
        frame(8'hD0, 8, 8'h00, 1'b1);
        flags(4'h8);
        engine(1'b0, 1'b0, 1'b0, 8'h00);
        flags(4'h0);
        engine(1'b1, 1'b1, 1'b0, 8'h03);
        st = 1;
        frame(8'h75, 8, 8'h00, 1'b0);
        engine(1'b0, 1'b0, 1'b0, 8'h00);
        @(posedge clk_in);
        #1 rst_in = 1'b1;
        repeat (2) @(posedge clk_in);
        #1 rst_in = 1'b0;
        wel_exp = 1'b0;
        flags(4'h0);
        finish_test();
    end

    // Only a hang runs this out
    initial
    begin
        repeat (60000) @(posedge clk_in);
        bad_count++;
        finish_test();
    end
endmodule
